// [hw/arem_pkg.sv]
/*
  Constants for the access rule entry matcher: register offsets, field
  positions, reset values and mode encodings.
  Assumes a 32-bit register port and a one-clock switch core.
*/
// Summary of operation
// - Match all ingress ports or one port
// - Policy number compared under mask when specific
// - Exactly one frame type selection held
// - Frame type any accepts every frame
// - Ethernet type needs type field >= 0x0600
// - ARP entry matches ARP and RARP only, never etype
// - IPv4 entry matches IPv4 only, never etype
// - Deny discards the hitting frame
// - Permit lets frame forward with other actions
// - Select rate limiter 1..16 or none
// - Optional policer 1..128, off after reset
// - Redirect to valid port, else no effect
// - Mirror copies hitting frames, off by default
// - Logging raises event, may drop when busy
// - Shutdown disables the arrival port on hit
// - Counter increments once per hitting frame
// - Source filter only for etype or ARP
// - Source address compared when specific
// - Destination classes: any, group, all, single
// - Specific destination compares full address
`default_nettype none
package arem_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_SEL = 8'h00;
  localparam logic [7:0] ADDR_POLICY   = 8'h04;
  localparam logic [7:0] ADDR_TYPE_ACT = 8'h08;
  localparam logic [7:0] ADDR_RATE     = 8'h0c;
  localparam logic [7:0] ADDR_POLICER  = 8'h10;
  localparam logic [7:0] ADDR_REDIRECT = 8'h14;
  localparam logic [7:0] ADDR_OPTIONS  = 8'h18;
  localparam logic [7:0] ADDR_SRC_CFG  = 8'h1c;
  localparam logic [7:0] ADDR_SRC_LO   = 8'h20;
  localparam logic [7:0] ADDR_SRC_HI   = 8'h24;
  localparam logic [7:0] ADDR_DST_CFG  = 8'h28;
  localparam logic [7:0] ADDR_DST_LO   = 8'h2c;
  localparam logic [7:0] ADDR_DST_HI   = 8'h30;
  localparam logic [7:0] ADDR_HIT_CNT  = 8'h34;
  localparam logic [7:0] ADDR_LOG_DROP = 8'h38;
  localparam logic [7:0] ADDR_STATUS   = 8'h3c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_NUM      = 8;   // Port number / policy value base
  localparam int POS_MASK     = 16;  // Policy mask base
  localparam int POS_DENY     = 4;   // Action bit in type/action word
  localparam int POS_MIRROR   = 0;
  localparam int POS_LOG      = 1;
  localparam int POS_SHUTDOWN = 2;

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX       = 32'hffff_ffff;
  localparam logic [4:0]  RATE_LAST     = 5'h10;  // Limiters 1..16
  localparam logic [7:0]  POLICER_LAST  = 8'h80;  // Policers 1..128
  localparam logic [15:0] ETYPE_MIN     = 16'h0600;
  localparam logic [15:0] ETYPE_ARP     = 16'h0806;
  localparam logic [15:0] ETYPE_RARP    = 16'h8035;
  localparam logic [15:0] ETYPE_IPV4    = 16'h0800;
  localparam logic [47:0] ADDR_ALL_ONES = 48'hffff_ffff_ffff;
  localparam int          LOG_GAP_CYC   = 16;     // Least spacing of log events

  // ---------------------------------------------------------------
  // Mode encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    AREM_FT_ANY   = 2'b00,
    AREM_FT_ETYPE = 2'b01,
    AREM_FT_ARP   = 2'b10,
    AREM_FT_IPV4  = 2'b11
  } arem_ftype_e;

  typedef enum logic [2:0] {
    AREM_DST_ANY      = 3'b000,
    AREM_DST_GROUP    = 3'b001,
    AREM_DST_ALL      = 3'b010,
    AREM_DST_SINGLE   = 3'b011,
    AREM_DST_SPECIFIC = 3'b100
  } arem_dst_e;

endpackage
`default_nettype wire

// [hw/arem_access_rule_entry.sv]
/*
  One access rule entry: classifies each parsed frame descriptor against
  the configured entry and issues the action set one cycle later.
  Assumes the descriptor comes from parser logic on the same clock and
  that software uses the plain register port with one-cycle strobes.
  No state machine: each verdict is combinational from config and
  descriptor, then registered, so the action set lags by one clock.
  Counters saturate; a write to a counter's offset clears it.
*/
`timescale 1ns/1ns
`default_nettype none
module arem_access_rule_entry
  import arem_pkg::*;
#(
  parameter int PORT_W    = 6,
  parameter int NUM_PORTS = 28
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Frame descriptor from the ingress parser
  input  wire logic              frm_valid,
  input  wire logic [PORT_W-1:0] frm_port,
  input  wire logic [7:0]        frm_policy,
  input  wire logic [15:0]       frm_len_type,
  input  wire logic [47:0]       frm_source_station_address,
  input  wire logic [47:0]       frm_destination_station_address,
  // Action set toward forwarding and queueing
  output logic                   act_valid,
  output logic                   act_hit,
  output logic                   act_drop,
  output logic                   act_forward,
  output logic                   act_rate_en,
  output logic      [3:0]        act_rate_idx,
  output logic                   act_policer_en,
  output logic      [6:0]        act_policer_idx,
  output logic                   act_redirect_en,
  output logic      [PORT_W-1:0] act_redirect_port,
  output logic                   act_mirror,
  output logic                   act_log,
  output logic                   act_shutdown,
  output logic      [PORT_W-1:0] act_shutdown_port
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Destination class of an address
  // All ones first: it has the group bit set too
  function automatic logic [1:0] dst_class(input logic [47:0] a);
    if (a == ADDR_ALL_ONES) begin
      dst_class = 2'h2;
    end else if (a[40]) begin
      dst_class = 2'h1;
    end else begin
      dst_class = 2'h3;
    end
  endfunction

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Match criteria
  logic              port_spec_ff;
  logic [PORT_W-1:0] port_num_ff;
  logic              pol_spec_ff;
  logic [7:0]        pol_val_ff;
  logic [7:0]        pol_mask_ff;
  arem_ftype_e       ftype_ff;

  // Actions
  logic              deny_ff;
  logic [4:0]        rate_ff;
  logic [7:0]        policer_ff;
  logic              redir_en_ff;
  logic [PORT_W-1:0] redir_port_ff;
  logic              mirror_ff;
  logic              log_en_ff;
  logic              shut_en_ff;

  // Address filters
  logic              src_spec_ff;
  logic [47:0]       src_addr_ff;
  arem_dst_e         dst_mode_ff;
  logic [47:0]       dst_addr_ff;

  // Counters and status
  logic [31:0]       hit_cnt_ff;
  logic [31:0]       log_drop_ff;
  logic              last_hit_ff;
  logic [4:0]        log_gap_ff;

  // Configuration writes; all actions off after reset
  // Unmapped offsets hit the default arm and are ignored
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_spec_ff  <= 1'b0;
      port_num_ff   <= '0;
      pol_spec_ff   <= 1'b0;
      pol_val_ff    <= RST_WORD[7:0];
      pol_mask_ff   <= RST_WORD[7:0];
      ftype_ff      <= AREM_FT_ANY;
      deny_ff       <= 1'b0;
      rate_ff       <= RST_WORD[4:0];
      policer_ff    <= RST_WORD[7:0];
      redir_en_ff   <= 1'b0;
      redir_port_ff <= '0;
      mirror_ff     <= 1'b0;
      log_en_ff     <= 1'b0;
      shut_en_ff    <= 1'b0;
      src_spec_ff   <= 1'b0;
      src_addr_ff   <= '0;
      dst_mode_ff   <= AREM_DST_ANY;
      dst_addr_ff   <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PORT_SEL: begin
          port_spec_ff <= reg_wdata[0];
          port_num_ff  <= reg_wdata[POS_NUM +: PORT_W];
        end
        ADDR_POLICY: begin
          pol_spec_ff <= reg_wdata[0];
          pol_val_ff  <= reg_wdata[POS_NUM +: 8];
          pol_mask_ff <= reg_wdata[POS_MASK +: 8];
        end
        ADDR_TYPE_ACT: begin
          ftype_ff <= arem_ftype_e'(reg_wdata[1:0]);
          deny_ff  <= reg_wdata[POS_DENY];
        end
        ADDR_RATE:    rate_ff    <= reg_wdata[4:0];
        ADDR_POLICER: policer_ff <= reg_wdata[7:0];
        ADDR_REDIRECT: begin
          redir_en_ff   <= reg_wdata[0];
          redir_port_ff <= reg_wdata[POS_NUM +: PORT_W];
        end
        ADDR_OPTIONS: begin
          mirror_ff  <= reg_wdata[POS_MIRROR];
          log_en_ff  <= reg_wdata[POS_LOG];
          shut_en_ff <= reg_wdata[POS_SHUTDOWN];
        end
        ADDR_SRC_CFG: src_spec_ff        <= reg_wdata[0];
        ADDR_SRC_LO:  src_addr_ff[31:0]  <= reg_wdata;
        ADDR_SRC_HI:  src_addr_ff[47:32] <= reg_wdata[15:0];
        ADDR_DST_CFG: begin
          // Codes above specific fall back to don't-care
          if (reg_wdata[2:0] > AREM_DST_SPECIFIC) begin
            dst_mode_ff <= AREM_DST_ANY;
          end else begin
            dst_mode_ff <= arem_dst_e'(reg_wdata[2:0]);
          end
        end
        ADDR_DST_LO:  dst_addr_ff[31:0]  <= reg_wdata;
        ADDR_DST_HI:  dst_addr_ff[47:32] <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Match logic
  // ---------------------------------------------------------------
  logic is_arp;
  logic is_ipv4;
  logic port_ok;
  logic pol_ok;
  logic type_ok;
  logic src_ok;
  logic dst_ok;
  logic hit;

  // Protocol recognition from the type field
  // RARP rides the ARP selection
  assign is_arp  = (frm_len_type == ETYPE_ARP) || (frm_len_type == ETYPE_RARP);
  assign is_ipv4 = (frm_len_type == ETYPE_IPV4);

  // Port and policy criteria
  // A zero mask lets a specific policy match any frame
  assign port_ok = !port_spec_ff || (frm_port == port_num_ff);
  assign pol_ok  = !pol_spec_ff ||
                   ((frm_policy & pol_mask_ff) == (pol_val_ff & pol_mask_ff));

  // Frame type criterion; ARP and IPv4 are kept out of etype entries
  // Both lie above 0x0600, so the range test alone is not enough
  always_comb begin
    unique case (ftype_ff)
      AREM_FT_ANY:   type_ok = 1'b1;
      AREM_FT_ETYPE: type_ok = (frm_len_type >= ETYPE_MIN) && !is_arp && !is_ipv4;
      AREM_FT_ARP:   type_ok = is_arp;
      AREM_FT_IPV4:  type_ok = is_ipv4;
    endcase
  end

  // Source filter only counts for etype and ARP entries
  // A stale specific address is harmless after a type change
  assign src_ok = !src_spec_ff ||
                  !((ftype_ff == AREM_FT_ETYPE) || (ftype_ff == AREM_FT_ARP)) ||
                  (frm_source_station_address == src_addr_ff);

  // Destination filter by class or full address
  // Default arm unreachable: writes fold bad codes to any
  always_comb begin
    unique case (dst_mode_ff)
      AREM_DST_ANY:      dst_ok = 1'b1;
      AREM_DST_GROUP:    dst_ok = dst_class(frm_destination_station_address) == 2'h1;
      AREM_DST_ALL:      dst_ok = dst_class(frm_destination_station_address) == 2'h2;
      AREM_DST_SINGLE:   dst_ok = dst_class(frm_destination_station_address) == 2'h3;
      AREM_DST_SPECIFIC: dst_ok = frm_destination_station_address == dst_addr_ff;
      default:           dst_ok = 1'b1;
    endcase
  end

  // Hit only when every criterion agrees
  assign hit = frm_valid && port_ok && pol_ok && type_ok && src_ok && dst_ok;

  // ---------------------------------------------------------------
  // Action set
  // ---------------------------------------------------------------
  // Out-of-range numbers switch the action off, never wrap
  logic rate_valid;
  logic pol_valid;
  logic redir_valid;
  logic log_free;
  logic log_take;
  logic log_lose;

  // Limiter and policer numbers are one-based; zero is off
  // Redirect beyond the last switch port is ignored
  assign rate_valid  = (rate_ff != 5'h00) && (rate_ff <= RATE_LAST);
  assign pol_valid   = (policer_ff != 8'h00) && (policer_ff <= POLICER_LAST);
  assign redir_valid = redir_en_ff && (redir_port_ff < PORT_W'(NUM_PORTS));
  assign log_free    = (log_gap_ff == 5'h00);
  assign log_take    = hit && log_en_ff && log_free;
  assign log_lose    = hit && log_en_ff && !log_free;

  // All actions leave together, one cycle after the descriptor
  // Index and port fields are not gated by hit;
  // consumers qualify them with the enable bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      act_valid         <= 1'b0;
      act_hit           <= 1'b0;
      act_drop          <= 1'b0;
      act_forward       <= 1'b0;
      act_rate_en       <= 1'b0;
      act_rate_idx      <= '0;
      act_policer_en    <= 1'b0;
      act_policer_idx   <= '0;
      act_redirect_en   <= 1'b0;
      act_redirect_port <= '0;
      act_mirror        <= 1'b0;
      act_log           <= 1'b0;
      act_shutdown      <= 1'b0;
      act_shutdown_port <= '0;
    end else begin
      act_valid         <= frm_valid;
      act_hit           <= hit;
      act_drop          <= hit && deny_ff;
      act_forward       <= hit && !deny_ff;
      act_rate_en       <= hit && rate_valid;
      act_rate_idx      <= rate_valid ? 4'(rate_ff - 5'h01) : 4'h0;
      act_policer_en    <= hit && pol_valid;
      act_policer_idx   <= pol_valid ? 7'(policer_ff - 8'h01) : 7'h00;
      act_redirect_en   <= hit && redir_valid;
      act_redirect_port <= redir_port_ff;
      act_mirror        <= hit && mirror_ff;
      act_log           <= log_take;
      act_shutdown      <= hit && shut_en_ff;
      act_shutdown_port <= frm_port;
    end
  end

  // Log pacing; a hit inside the gap is dropped and counted
  // The gap bounds the event rate toward the processor;
  // a clear beside a drop leaves the count at one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      log_gap_ff  <= '0;
      log_drop_ff <= RST_WORD;
    end else begin
      // Gap opens on a logged hit, then runs down to zero
      if (log_take) begin
        log_gap_ff <= 5'(LOG_GAP_CYC - 1);
      end else if (!log_free) begin
        log_gap_ff <= log_gap_ff - 5'h01;
      end
      // Drop count, cleared by any write to its offset
      if (reg_wr && (reg_addr == ADDR_LOG_DROP)) begin
        log_drop_ff <= {31'h0, log_lose};
      end else if (log_lose && (log_drop_ff != CNT_MAX)) begin
        log_drop_ff <= log_drop_ff + 32'h0000_0001;
      end
    end
  end

  // Hit counter; a hit in the clearing cycle still counts
  // Saturating, so a long run never reads back as small
  // last_hit_ff holds through idle cycles for the status word
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hit_cnt_ff  <= RST_WORD;
      last_hit_ff <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == ADDR_HIT_CNT)) begin
        hit_cnt_ff <= {31'h0, hit};
      end else if (hit && (hit_cnt_ff != CNT_MAX)) begin
        hit_cnt_ff <= hit_cnt_ff + 32'h0000_0001;
      end
      if (frm_valid) begin
        last_hit_ff <= hit;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  logic [31:0] nxt_rdata;

  // Fields sit where writes put them; reads clear nothing
  always_comb begin
    nxt_rdata = '0;
    unique case (reg_addr)
      ADDR_PORT_SEL: nxt_rdata = {16'h0000, 8'(port_num_ff), 7'h00, port_spec_ff};
      ADDR_POLICY:   nxt_rdata = {8'h00, pol_mask_ff, pol_val_ff, 7'h00, pol_spec_ff};
      ADDR_TYPE_ACT: nxt_rdata = {27'h0, deny_ff, 2'b00, ftype_ff};
      ADDR_RATE:     nxt_rdata = {27'h0, rate_ff};
      ADDR_POLICER:  nxt_rdata = {24'h000000, policer_ff};
      ADDR_REDIRECT: nxt_rdata = {16'h0000, 8'(redir_port_ff), 7'h00, redir_en_ff};
      ADDR_OPTIONS:  nxt_rdata = {29'h0, shut_en_ff, log_en_ff, mirror_ff};
      ADDR_SRC_CFG:  nxt_rdata = {31'h0, src_spec_ff};
      ADDR_SRC_LO:   nxt_rdata = src_addr_ff[31:0];
      ADDR_SRC_HI:   nxt_rdata = {16'h0000, src_addr_ff[47:32]};
      ADDR_DST_CFG:  nxt_rdata = {29'h0, dst_mode_ff};
      ADDR_DST_LO:   nxt_rdata = dst_addr_ff[31:0];
      ADDR_DST_HI:   nxt_rdata = {16'h0000, dst_addr_ff[47:32]};
      ADDR_HIT_CNT:  nxt_rdata = hit_cnt_ff;
      ADDR_LOG_DROP: nxt_rdata = log_drop_ff;
      ADDR_STATUS:   nxt_rdata = {30'h0, !log_free, last_hit_ff};
      default:       nxt_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero when idle, so entries can share a wired-OR bus
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= RST_WORD;
    end else begin
      reg_rdata <= reg_rd ? nxt_rdata : RST_WORD;
    end
  end

endmodule
`default_nettype wire

// [dv/arem_parser_model.sv]
/*
  Ingress parser stand-in: issues one frame descriptor per send call.
  Assumes the caller runs on the entry's core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module arem_parser_model
  import arem_pkg::*;
#(
  parameter int PORT_W = 6
) (
  // Clock
  input  wire logic              clock,
  // Descriptor toward the entry
  output var logic               frm_valid,
  output var logic [PORT_W-1:0]  frm_port,
  output var logic [7:0]         frm_policy,
  output var logic [15:0]        frm_len_type,
  output var logic [47:0]        frm_sa,
  output var logic [47:0]        frm_da
);
  // ---------------------------------------------------------------
  // Descriptor driver
  // ---------------------------------------------------------------
  // Idle at time zero
  initial begin
    frm_valid    = 1'b0;
    frm_port     = '0;
    frm_policy   = 8'h00;
    frm_len_type = 16'h0000;
    frm_sa       = 48'h0;
    frm_da       = 48'h0;
  end

  // One-cycle pulse; fields inverted afterwards so stale values never match
  task automatic send(input logic [PORT_W-1:0] p, input logic [7:0] pol,
                      input logic [15:0] lt, input logic [47:0] sa, input logic [47:0] da);
    @(posedge clock);
    frm_valid    <= 1'b1;
    frm_port     <= p;
    frm_policy   <= pol;
    frm_len_type <= lt;
    frm_sa       <= sa;
    frm_da       <= da;
    @(posedge clock);
    frm_valid    <= 1'b0;
    frm_port     <= ~p;
    frm_policy   <= ~pol;
    frm_len_type <= ~lt;
    frm_sa       <= ~sa;
    frm_da       <= ~da;
  endtask
endmodule
`default_nettype wire

// [dv/arem_entry_assertions.sv]
/*
  Checker for the entry's action outputs.
  Assumes it is bound into the entry and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module arem_entry_assertions #(
  parameter int PORT_W    = 6,
  parameter int NUM_PORTS = 28
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              arst_n,
  // Descriptor and action set
  input wire logic              frm_valid,
  input wire logic [PORT_W-1:0] frm_port,
  input wire logic              act_valid,
  input wire logic              act_hit,
  input wire logic              act_drop,
  input wire logic              act_forward,
  input wire logic              act_rate_en,
  input wire logic              act_policer_en,
  input wire logic              act_redirect_en,
  input wire logic [PORT_W-1:0] act_redirect_port,
  input wire logic              act_mirror,
  input wire logic              act_log,
  input wire logic              act_shutdown,
  input wire logic [PORT_W-1:0] act_shutdown_port
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_answer_next: assert property (frm_valid |=> act_valid)
    else $error("descriptor not answered next cycle");
  a_hit_has_cause: assert property (act_hit |-> act_valid && $past(frm_valid))
    else $error("hit without descriptor");
  a_one_verdict: assert property (!(act_drop && act_forward) && act_hit == (act_drop || act_forward))
    else $error("drop and forward disagree with hit");
  a_rate_on_hit: assert property (act_rate_en |-> act_hit)
    else $error("limiter applied without hit");
  a_policer_on_hit: assert property (act_policer_en |-> act_hit)
    else $error("policer applied without hit");
  a_redirect_legal: assert property (act_redirect_en |-> act_hit && act_redirect_port < NUM_PORTS)
    else $error("redirect to illegal port or without hit");
  a_mirror_on_hit: assert property (act_mirror |-> act_hit)
    else $error("mirror without hit");
  a_log_gap: assert property (act_log |=> !act_log [*8] ##1 !act_log [*7])
    else $error("log events too close");
  a_shut_port: assert property (act_shutdown |-> act_hit && act_shutdown_port == $past(frm_port))
    else $error("shutdown port is not the arrival port");
endmodule

bind arem_access_rule_entry arem_entry_assertions #(
  .PORT_W(PORT_W), .NUM_PORTS(NUM_PORTS)
) i_arem_entry_assertions (
  .clock, .arst_n, .frm_valid, .frm_port, .act_valid, .act_hit, .act_drop, .act_forward,
  .act_rate_en, .act_policer_en, .act_redirect_en, .act_redirect_port, .act_mirror,
  .act_log, .act_shutdown, .act_shutdown_port
);
`default_nettype wire

// [dv/arem_access_rule_entry_bench.sv]
/*
  Self-checking bench for one access rule entry: register calls and frames.
  Assumes the parser model drives the descriptor port.
*/
`timescale 1ns/1ns
`default_nettype none
module arem_access_rule_entry_bench
  import arem_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int PW = 6;
  logic          clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic [31:0]   reg_wdata = 32'h0, reg_rdata, d;
  wire logic          frm_valid;
  wire logic [PW-1:0] frm_port;
  wire logic [7:0]    frm_policy;
  wire logic [15:0]   frm_len_type;
  wire logic [47:0]   frm_sa, frm_da;
  logic act_valid, act_hit, act_drop, act_forward, act_rate_en, act_policer_en;
  logic act_redirect_en, act_mirror, act_log, act_shutdown;
  logic [3:0]    act_rate_idx;
  logic [6:0]    act_policer_idx;
  logic [PW-1:0] act_redirect_port, act_shutdown_port;
  int n_fail = 0, n_tests = 0, exp_cnt = 0, cycles = 0;
  logic [47:0] dsa = 48'h1122_3344_5566, dda = 48'h0000_00aa_bbcc;
  logic [15:0] lt_tab [6] = '{16'h05ff, 16'h0600, 16'h0806, 16'h8035, 16'h0800, 16'h88cc};
  logic [5:0]  ft_hits [4] = '{6'b111111, 6'b100010, 6'b001100, 6'b010000};
  logic [47:0] da_tab [4];
  logic [3:0]  dst_hits [5] = '{4'b1111, 4'b0010, 4'b0001, 4'b1100, 4'b1000};

  always #2 clock = ~clock;

  arem_access_rule_entry #(.PORT_W(PW), .NUM_PORTS(28)) i_arem_access_rule_entry (
    .clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frm_valid,
    .frm_port, .frm_policy, .frm_len_type, .frm_source_station_address(frm_sa),
    .frm_destination_station_address(frm_da), .act_valid, .act_hit, .act_drop,
    .act_forward, .act_rate_en, .act_rate_idx, .act_policer_en, .act_policer_idx,
    .act_redirect_en, .act_redirect_port, .act_mirror, .act_log, .act_shutdown,
    .act_shutdown_port);
  arem_parser_model #(.PORT_W(PW)) i_arem_parser_model (
    .clock, .frm_valid, .frm_port, .frm_policy, .frm_len_type, .frm_sa, .frm_da);

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic frame(input logic [PW-1:0] p, input logic [7:0] pol, input logic [15:0] lt,
                       input logic [47:0] sa, input logic [47:0] da, input logic hit);
    i_arem_parser_model.send(p, pol, lt, sa, da);
    #1;
    chk(act_valid, 1'b1);
    chk(act_hit, hit);
    if (hit === 1'b1) exp_cnt++;
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    da_tab = '{48'hffff_ffff_ffff, 48'h0100_0000_0001, 48'h0000_0000_0002, dda};
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    // Every word cleared, one unmapped place beyond the map
    for (int i = 0; i < 17; i++) begin
      rd(8'(i * 4));
      chk(d, 32'h0);
    end
    frame(3, 8'h00, 16'h0800, dsa, dda, 1'b1);
    chk({act_forward, act_drop, act_rate_en, act_policer_en, act_redirect_en}, 5'h10);
    chk({act_mirror, act_log, act_shutdown}, 3'b000);
    wr(ADDR_PORT_SEL, 32'h0000_0501);
    frame(5, 8'h00, 16'h0800, dsa, dda, 1'b1);
    frame(6, 8'h00, 16'h0800, dsa, dda, 1'b0);
    wr(ADDR_PORT_SEL, 32'h0);
    wr(ADDR_POLICY, 32'h00f0_5a01);
    frame(3, 8'h53, 16'h0800, dsa, dda, 1'b1);
    frame(3, 8'h6a, 16'h0800, dsa, dda, 1'b0);
    rd(ADDR_POLICY);
    chk(d, 32'h00f0_5a01);
    wr(ADDR_POLICY, 32'h0);
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_TYPE_ACT, 32'(t));
      for (int k = 0; k < 6; k++) frame(3, 8'h00, lt_tab[k], dsa, dda, ft_hits[t][k]);
    end
    wr(ADDR_SRC_CFG, 32'h1);
    wr(ADDR_SRC_LO, 32'h3344_5566);
    wr(ADDR_SRC_HI, 32'h0000_1122);
    frame(3, 8'h00, 16'h0800, ~dsa, dda, 1'b1);
    wr(ADDR_TYPE_ACT, 32'h1);
    frame(3, 8'h00, 16'h88cc, dsa, dda, 1'b1);
    frame(3, 8'h00, 16'h88cc, ~dsa, dda, 1'b0);
    wr(ADDR_SRC_CFG, 32'h0);
    wr(ADDR_DST_LO, 32'h00aa_bbcc);
    wr(ADDR_DST_HI, 32'h0);
    for (int c = 0; c < 5; c++) begin
      wr(ADDR_DST_CFG, 32'(c));
      for (int k = 0; k < 4; k++) frame(3, 8'h00, 16'h88cc, dsa, da_tab[k], dst_hits[c][k]);
    end
    wr(ADDR_DST_CFG, 32'h7);
    rd(ADDR_DST_CFG);
    chk(d, 32'h0);
    // Full action set, then a logged hit too soon after the first
    wr(ADDR_TYPE_ACT, 32'h11);
    wr(ADDR_RATE, 32'd16);
    wr(ADDR_POLICER, 32'd128);
    wr(ADDR_REDIRECT, 32'h0000_1b01);
    wr(ADDR_OPTIONS, 32'h7);
    frame(9, 8'h00, 16'h88cc, dsa, dda, 1'b1);
    chk({act_drop, act_forward}, 2'b10);
    chk({act_rate_en, act_rate_idx}, 5'h1f);
    chk({act_policer_en, act_policer_idx}, 8'hff);
    chk({act_redirect_en, act_redirect_port}, {1'b1, 6'd27});
    chk({act_mirror, act_log, act_shutdown, act_shutdown_port}, {3'b111, 6'd9});
    frame(9, 8'h00, 16'h88cc, dsa, dda, 1'b1);
    chk(act_log, 1'b0);
    wr(ADDR_RATE, 32'd17);
    wr(ADDR_REDIRECT, 32'h0000_1c01);
    frame(9, 8'h00, 16'h88cc, dsa, dda, 1'b1);
    chk({act_rate_en, act_redirect_en, act_drop}, 3'b001);
    rd(ADDR_STATUS);
    chk(d, 32'h3);
    rd(ADDR_LOG_DROP);
    chk(d, 32'd2);
    wr(ADDR_LOG_DROP, 32'h0);
    rd(ADDR_LOG_DROP);
    chk(d, 32'h0);
    rd(ADDR_HIT_CNT);
    chk(d, 32'(exp_cnt));
    wr(ADDR_HIT_CNT, 32'h0);
    rd(ADDR_HIT_CNT);
    chk(d, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
